// file: core/banked_data_memory_map.sv
// Functional notes
// - page holds 128 nibbles, 8 rows x 16 columns
// - row/column from operand, page from page select
// - one nibble location per instruction
// - 74H to 7FH decode to system registers
// - system registers mirrored in every page
// - fixed layout of system register fields
// - six kinds of system register provided
// - system registers accessed like ordinary memory
// - page 0 0CH-0FH decode to data buffer
// - pages 0-3 70H-73H decode to ports
// - page 15 60H-6FH decode to direction registers
// - page 15 00H-5FH has no storage
// - general RAM fills all remaining locations
// - large variant RAM on pages 0 to 15
// - small variant RAM only pages 0 to 9 and page 15 70H-73H
// - small variant lacks pages 10 to 14
// - unimplemented reads return undefined value
// - unimplemented writes change nothing
// - full arithmetic, logic, compare, transfer, test set
// - direction registers page 15 in both variants
`default_nettype none
module banked_data_memory_map #(
    parameter bit LARGE_VARIANT = 1'b1
) (
    // clock and reset
    input  wire logic        clock,
    input  wire logic        sys_rst,
    // core request
    input  wire logic        accessValid,
    input  wire banked_mem_pkg::mem_op_type accessOp,
    input  wire logic [2:0]  rowIndex,
    input  wire logic [3:0]  columnIndex,
    input  wire logic [3:0]  operandValue,
    // core answer
    output logic             answerValid_reg,
    output logic [3:0]       readValue_reg,
    output logic             skipNext_reg,
    output logic             carryFlag_reg,
    output logic [2:0]       answerTarget_reg,
    // peripheral side: data buffer, ports, direction registers
    output logic             periphWrite_reg,
    output logic [2:0]       periphTarget_reg,
    output logic [5:0]       periphIndex_reg,
    output logic [3:0]       periphData_reg,
    input  wire logic [3:0]  bufferReadData,
    input  wire logic [3:0]  portReadData,
    input  wire logic [3:0]  directionReadData,
    // system register view
    output logic [3:0]       memoryPageSelect_reg,
    output logic [15:0]      programAddress_reg,
    output logic [3:0]       transferWindow_reg,
    output logic [11:0]      indexModifier_reg,
    output logic [7:0]       generalRegisterPointer_reg,
    output logic [3:0]       programStatusWord_reg
);
    // ****************************************
    // address formation and decode
    // ****************************************
    logic [6:0]  pageOffset;
    logic [10:0] flatAddr;
    banked_mem_pkg::target_type target;

    assign pageOffset = {rowIndex, columnIndex};
    assign flatAddr   = {memoryPageSelect_reg, pageOffset};

    always_comb begin
        target = banked_mem_pkg::TGT_RAM;
        if (pageOffset >= banked_mem_pkg::SYS_FIRST) begin
            target = banked_mem_pkg::TGT_SYS;
        end else if (!LARGE_VARIANT && memoryPageSelect_reg != banked_mem_pkg::TOP_PAGE &&
                     memoryPageSelect_reg > banked_mem_pkg::SMALL_LAST_PAGE) begin
            // missing pages swallow the port row too, else it would reach ram
            target = banked_mem_pkg::TGT_NONE;
        end else if (pageOffset >= banked_mem_pkg::PORT_FIRST) begin
            target = (memoryPageSelect_reg <= banked_mem_pkg::PORT_LAST_PAGE)
                     ? banked_mem_pkg::TGT_PORT : banked_mem_pkg::TGT_RAM;
        end else if (memoryPageSelect_reg == banked_mem_pkg::TOP_PAGE) begin
            target = (pageOffset >= banked_mem_pkg::DIR_FIRST)
                     ? banked_mem_pkg::TGT_DIR : banked_mem_pkg::TGT_NONE;
        end else if (memoryPageSelect_reg == 4'h0 &&
                     pageOffset >= banked_mem_pkg::BUF_FIRST &&
                     pageOffset <= banked_mem_pkg::BUF_LAST) begin
            target = banked_mem_pkg::TGT_BUF;
        end
    end

    // ****************************************
    // system register file, twelve nibbles
    // ****************************************
    // six kinds: address, window, page, index, pointer, status (index doubles as row ptr)
    logic [3:0] sysNibble [0:banked_mem_pkg::SYS_NIBBLES-1];
    logic [3:0] sysIndex;
    assign sysIndex = 4'(pageOffset - banked_mem_pkg::SYS_FIRST);

    // ****************************************
    // two-phase access: read then modify
    // ****************************************
    // one-cycle ram read latency forces a second phase; the core waits for answerValid
    typedef enum { IDLE, EXEC } phase_type;
    phase_type phase_reg;
    banked_mem_pkg::target_type heldTarget_reg;
    banked_mem_pkg::mem_op_type heldOp_reg;
    logic [10:0] heldAddr_reg;
    logic [3:0]  heldSysIndex_reg;
    logic [5:0]  heldPeriphIndex_reg;
    logic [3:0]  heldOperand_reg;

    always_ff @(posedge clock) begin
        if (sys_rst) begin
            phase_reg <= IDLE;
        end else begin
            unique case (phase_reg)
                IDLE: if (accessValid) phase_reg <= EXEC;
                EXEC: phase_reg <= IDLE;
            endcase
        end
    end

    always_ff @(posedge clock) begin
        if (sys_rst) begin
            heldTarget_reg      <= banked_mem_pkg::TGT_NONE;
            heldOp_reg          <= banked_mem_pkg::OP_LOAD_FROM_MEMORY;
        end else if (phase_reg == IDLE && accessValid) begin
            heldTarget_reg      <= target;
            heldOp_reg          <= accessOp;
            heldAddr_reg        <= flatAddr;
            heldSysIndex_reg    <= sysIndex;
            heldPeriphIndex_reg <= (target == banked_mem_pkg::TGT_DIR)
                                   ? {2'h0, columnIndex}
                                   : (target == banked_mem_pkg::TGT_PORT)
                                   ? {2'h0, memoryPageSelect_reg[1:0], columnIndex[1:0]}
                                   : {4'h0, columnIndex[1:0]};
            heldOperand_reg     <= operandValue;
        end
    end

    // ****************************************
    // memory value and operation
    // ****************************************
    logic [3:0] ramReadData;
    logic [3:0] memValue;
    logic [3:0] aluResult;
    logic       aluCarry;
    logic       aluSkip;
    logic       aluWrite;
    logic       doWrite;

    always_comb begin
        unique case (heldTarget_reg)
            banked_mem_pkg::TGT_RAM:  memValue = ramReadData;
            banked_mem_pkg::TGT_SYS:  memValue = sysNibble[heldSysIndex_reg];
            banked_mem_pkg::TGT_BUF:  memValue = bufferReadData;
            banked_mem_pkg::TGT_PORT: memValue = portReadData;
            banked_mem_pkg::TGT_DIR:  memValue = directionReadData;
            default:                  memValue = banked_mem_pkg::UNDEF_READ;
        endcase
    end

    nibble_alu alu (
        .memValue  (memValue),
        .operand   (heldOperand_reg),
        .carryIn   (carryFlag_reg),
        .op        (heldOp_reg),
        .result    (aluResult),
        .carryOut  (aluCarry),
        .skip      (aluSkip),
        .writeBack (aluWrite)
    );

    assign doWrite = (phase_reg == EXEC) && aluWrite &&
                     (heldTarget_reg != banked_mem_pkg::TGT_NONE);

    nibble_ram ram (
        .clock     (clock),
        .writeEn   (doWrite && heldTarget_reg == banked_mem_pkg::TGT_RAM),
        .addr      ((phase_reg == EXEC) ? heldAddr_reg : flatAddr),
        .writeData (aluResult),
        .readData  (ramReadData)
    );

    // ****************************************
    // system register storage
    // ****************************************
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            for (int i = 0; i < banked_mem_pkg::SYS_NIBBLES; i++) begin
                sysNibble[i] <= banked_mem_pkg::SYS_RESET;
            end
        end else if (doWrite && heldTarget_reg == banked_mem_pkg::TGT_SYS) begin
            sysNibble[heldSysIndex_reg] <= aluResult;
        end
    end

    // field views, program address nibble 74H is the high one
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            programAddress_reg         <= 16'h0000;
            transferWindow_reg         <= 4'h0;
            memoryPageSelect_reg       <= 4'h0;
            indexModifier_reg          <= 12'h000;
            generalRegisterPointer_reg <= 8'h00;
            programStatusWord_reg      <= 4'h0;
        end else begin
            programAddress_reg         <= {sysNibble[0], sysNibble[1],
                                           sysNibble[2], sysNibble[3]};
            transferWindow_reg         <= sysNibble[4];
            indexModifier_reg          <= {sysNibble[6], sysNibble[7], sysNibble[8]};
            generalRegisterPointer_reg <= {sysNibble[9], sysNibble[10]};
            programStatusWord_reg      <= sysNibble[11];
            // page select follows the write at once so back-to-back accesses see it
            if (doWrite && heldTarget_reg == banked_mem_pkg::TGT_SYS &&
                heldSysIndex_reg == banked_mem_pkg::PAGE_SEL_INDEX) begin
                memoryPageSelect_reg <= aluResult;
            end
        end
    end

    // ****************************************
    // answers to core and peripherals
    // ****************************************
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            answerValid_reg  <= 1'b0;
            readValue_reg    <= 4'h0;
            skipNext_reg     <= 1'b0;
            carryFlag_reg    <= 1'b0;
            answerTarget_reg <= 3'h0;
            periphWrite_reg  <= 1'b0;
            periphTarget_reg <= 3'h0;
            periphIndex_reg  <= 6'h00;
            periphData_reg   <= 4'h0;
        end else begin
            answerValid_reg <= (phase_reg == EXEC);
            periphWrite_reg <= 1'b0;
            if (phase_reg == EXEC) begin
                readValue_reg    <= memValue;
                skipNext_reg     <= aluSkip;
                carryFlag_reg    <= aluCarry;
                answerTarget_reg <= heldTarget_reg;
                periphTarget_reg <= heldTarget_reg;
                periphIndex_reg  <= heldPeriphIndex_reg;
                periphData_reg   <= aluResult;
                periphWrite_reg  <= doWrite &&
                                    heldTarget_reg != banked_mem_pkg::TGT_RAM &&
                                    heldTarget_reg != banked_mem_pkg::TGT_SYS;
            end
        end
    end

    // ****************************************
    // checks
    // ****************************************
    answer_timing_a: assert property (@(posedge clock) disable iff (sys_rst)
        (phase_reg == IDLE && accessValid) |-> ##2 answerValid_reg)
        else $error("answer not two cycles after request");
    answer_single_a: assert property (@(posedge clock) disable iff (sys_rst)
        answerValid_reg |=> !answerValid_reg)
        else $error("answer longer than one cycle");
    sys_decode_a: assert property (@(posedge clock) disable iff (sys_rst)
        (phase_reg == IDLE && accessValid && {rowIndex, columnIndex} >= 7'h74)
        |-> ##2 answerTarget_reg == 3'(banked_mem_pkg::TGT_SYS))
        else $error("system area not decoded");
    top_empty_a: assert property (@(posedge clock) disable iff (sys_rst)
        (phase_reg == IDLE && accessValid && memoryPageSelect_reg == 4'hf &&
         rowIndex < 3'h6) |-> ##2 answerTarget_reg == 3'(banked_mem_pkg::TGT_NONE))
        else $error("page 15 low area not empty");
    dir_decode_a: assert property (@(posedge clock) disable iff (sys_rst)
        (phase_reg == IDLE && accessValid && memoryPageSelect_reg == 4'hf &&
         rowIndex == 3'h6) |-> ##2 answerTarget_reg == 3'(banked_mem_pkg::TGT_DIR))
        else $error("direction area not decoded");
    port_decode_a: assert property (@(posedge clock) disable iff (sys_rst)
        (phase_reg == IDLE && accessValid && memoryPageSelect_reg < 4'h4 &&
         rowIndex == 3'h7 && columnIndex < 4'h4)
        |-> ##2 answerTarget_reg == 3'(banked_mem_pkg::TGT_PORT))
        else $error("port area not decoded");
    small_gap_a: assert property (@(posedge clock) disable iff (sys_rst)
        (!LARGE_VARIANT && phase_reg == IDLE && accessValid &&
         memoryPageSelect_reg inside {[4'ha:4'he]} && {rowIndex, columnIndex} < 7'h74)
        |-> ##2 answerTarget_reg == 3'(banked_mem_pkg::TGT_NONE))
        else $error("missing page decoded");
    none_write_a: assert property (@(posedge clock) disable iff (sys_rst)
        (phase_reg == EXEC && heldTarget_reg == banked_mem_pkg::TGT_NONE)
        |=> !periphWrite_reg && $stable(memoryPageSelect_reg))
        else $error("write to empty location had effect");
    buf_decode_a: assert property (@(posedge clock) disable iff (sys_rst)
        (phase_reg == IDLE && accessValid && memoryPageSelect_reg == 4'h0 &&
         rowIndex == 3'h0 && columnIndex >= 4'hc)
        |-> ##2 answerTarget_reg == 3'(banked_mem_pkg::TGT_BUF))
        else $error("data buffer not decoded");

    sys_access_c: cover property (@(posedge clock)
        answerValid_reg && answerTarget_reg == 3'(banked_mem_pkg::TGT_SYS));
    skip_taken_c: cover property (@(posedge clock) answerValid_reg && skipNext_reg);
    periph_write_c: cover property (@(posedge clock) periphWrite_reg);
    none_access_c: cover property (@(posedge clock)
        answerValid_reg && answerTarget_reg == 3'(banked_mem_pkg::TGT_NONE));
endmodule
`default_nettype wire

// file: core/banked_mem_pkg.sv
`default_nettype none
package banked_mem_pkg;
    // ****************************************
    // geometry
    // ****************************************
    localparam int unsigned PAGE_NIBBLES    = 128;
    localparam int unsigned PAGE_COUNT      = 16;
    localparam int unsigned ADDR_W          = 11;
    localparam int unsigned RAM_WORDS       = 2048;
    // ****************************************
    // decode boundaries (offset within page)
    // ****************************************
    localparam logic [6:0] SYS_FIRST        = 7'h74;
    localparam logic [6:0] SYS_LAST         = 7'h7f;
    localparam logic [6:0] PORT_FIRST       = 7'h70;
    localparam logic [6:0] PORT_LAST        = 7'h73;
    localparam logic [6:0] DIR_FIRST        = 7'h60;
    localparam logic [6:0] DIR_LAST         = 7'h6f;
    localparam logic [6:0] BUF_FIRST        = 7'h0c;
    localparam logic [6:0] BUF_LAST         = 7'h0f;
    localparam logic [3:0] PORT_LAST_PAGE   = 4'h3;
    localparam logic [3:0] TOP_PAGE         = 4'hf;
    localparam logic [3:0] SMALL_LAST_PAGE  = 4'h9;
    // ****************************************
    // system register offsets
    // ****************************************
    localparam logic [6:0] ADDR_REG_OFF     = 7'h74;
    localparam logic [6:0] WINDOW_OFF       = 7'h78;
    localparam logic [6:0] PAGE_SEL_OFF     = 7'h79;
    localparam logic [6:0] INDEX_OFF        = 7'h7a;
    localparam logic [6:0] GRP_OFF          = 7'h7d;
    localparam logic [6:0] STATUS_OFF       = 7'h7f;
    localparam logic [3:0] SYS_RESET        = 4'h0;
    localparam int unsigned SYS_NIBBLES     = 12;
    localparam logic [3:0] PAGE_SEL_INDEX   = 4'h5;
    localparam logic [3:0] UNDEF_READ       = 4'h0;
    // ****************************************
    // decoded targets and operations
    // ****************************************
    typedef enum logic [2:0] {
        TGT_RAM, TGT_SYS, TGT_BUF, TGT_PORT, TGT_DIR, TGT_NONE
    } target_type;
    typedef enum logic [3:0] {
        OP_ADD, OP_ADD_WITH_CARRY, OP_SUB, OP_SUBTRACT_WITH_BORROW,
        OP_AND, OP_OR, OP_XOR,
        OP_SKIP_IF_EQUAL, OP_SKIP_IF_GREATER_EQUAL, OP_SKIP_IF_LESS,
        OP_SKIP_IF_NOT_EQUAL,
        OP_TRANSFER_BETWEEN_CELLS, OP_LOAD_FROM_MEMORY, OP_WRITE_TO_MEMORY,
        OP_SKIP_IF_BITS_TRUE, OP_SKIP_IF_BITS_FALSE
    } mem_op_type;
endpackage
`default_nettype wire

// file: core/nibble_ram.sv
`default_nettype none
module nibble_ram (
    // clock
    input  wire logic        clock,
    // port
    input  wire logic        writeEn,
    input  wire logic [10:0] addr,
    input  wire logic [3:0]  writeData,
    output var  logic [3:0]  readData
);
    // no reset: contents are undefined after power-on by design
    logic [3:0] cells [0:banked_mem_pkg::RAM_WORDS-1];

    always_ff @(posedge clock) begin
        if (writeEn) begin
            cells[addr] <= writeData;
        end
        readData <= cells[addr];
    end
endmodule
`default_nettype wire

// file: core/nibble_alu.sv
`default_nettype none
module nibble_alu (
    // operands
    input  wire logic [3:0] memValue,
    input  wire logic [3:0] operand,
    input  wire logic       carryIn,
    input  wire banked_mem_pkg::mem_op_type op,
    // results
    output logic      [3:0] result,
    output logic            carryOut,
    output logic            skip,
    output logic            writeBack
);
    logic [4:0] wide;

    always_comb begin
        wide      = 5'h00;
        result    = memValue;
        carryOut  = carryIn;
        skip      = 1'b0;
        writeBack = 1'b0;
        unique case (op)
            banked_mem_pkg::OP_ADD: begin
                wide = {1'b0, memValue} + {1'b0, operand};
                result = wide[3:0]; carryOut = wide[4]; writeBack = 1'b1;
            end
            banked_mem_pkg::OP_ADD_WITH_CARRY: begin
                wide = {1'b0, memValue} + {1'b0, operand} + {4'h0, carryIn};
                result = wide[3:0]; carryOut = wide[4]; writeBack = 1'b1;
            end
            banked_mem_pkg::OP_SUB: begin
                wide = {1'b0, memValue} - {1'b0, operand};
                result = wide[3:0]; carryOut = wide[4]; writeBack = 1'b1;
            end
            banked_mem_pkg::OP_SUBTRACT_WITH_BORROW: begin
                wide = {1'b0, memValue} - {1'b0, operand} - {4'h0, carryIn};
                result = wide[3:0]; carryOut = wide[4]; writeBack = 1'b1;
            end
            banked_mem_pkg::OP_AND: begin
                result = memValue & operand; writeBack = 1'b1;
            end
            banked_mem_pkg::OP_OR: begin
                result = memValue | operand; writeBack = 1'b1;
            end
            banked_mem_pkg::OP_XOR: begin
                result = memValue ^ operand; writeBack = 1'b1;
            end
            banked_mem_pkg::OP_SKIP_IF_EQUAL:         skip = (memValue == operand);
            banked_mem_pkg::OP_SKIP_IF_GREATER_EQUAL: skip = (memValue >= operand);
            banked_mem_pkg::OP_SKIP_IF_LESS:          skip = (memValue < operand);
            banked_mem_pkg::OP_SKIP_IF_NOT_EQUAL:     skip = (memValue != operand);
            banked_mem_pkg::OP_TRANSFER_BETWEEN_CELLS,
            banked_mem_pkg::OP_WRITE_TO_MEMORY: begin
                result = operand; writeBack = 1'b1;
            end
            banked_mem_pkg::OP_LOAD_FROM_MEMORY: result = memValue;
            banked_mem_pkg::OP_SKIP_IF_BITS_TRUE:  skip = ((memValue & operand) == operand);
            banked_mem_pkg::OP_SKIP_IF_BITS_FALSE: skip = ((memValue & operand) == 4'h0);
        endcase
    end
endmodule
`default_nettype wire

// file: dv/core_model.sv
`default_nettype none
// ****************************************
// processor core issuing nibble requests
// ****************************************
module core_model (
    // clock
    input  wire logic                       clock,
    // request
    output var  logic                       accessValid,
    output var  banked_mem_pkg::mem_op_type accessOp,
    output var  logic [2:0]                 rowIndex,
    output var  logic [3:0]                 columnIndex,
    output var  logic [3:0]                 operandValue,
    // answer
    input  wire logic                       answerValid_reg
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        accessValid = 1'b0;
        accessOp = banked_mem_pkg::OP_LOAD_FROM_MEMORY;
        {rowIndex, columnIndex} = 7'h00;
        operandValue = 4'h0;
    end
    // one nibble per request, next one only after the answer
    task automatic access(input banked_mem_pkg::mem_op_type op, input logic [6:0] loc,
                          input logic [3:0] val, output bit ok);
        int n;
        @(posedge clock);
        accessValid <= 1'b1;
        accessOp <= op;
        {rowIndex, columnIndex} <= loc;
        operandValue <= val;
        @(posedge clock);
        accessValid <= 1'b0;
        // released lines flip so a stale address never looks valid
        {rowIndex, columnIndex} <= ~loc;
        operandValue <= ~val;
        ok = 1'b0;
        for (n = 0; n < 4 && !ok; n++) begin
            @(negedge clock);
            ok = (answerValid_reg === 1'b1);
        end
    endtask
endmodule
`default_nettype wire

// file: dv/banked_data_memory_map_tb.sv
`default_nettype none
module banked_data_memory_map_tb;
    timeunit 1ns;
    timeprecision 1ps;
    // ****************************************
    // signals
    // ****************************************
    logic clock = 1'b0, sys_rst = 1'b1, accessValid;
    banked_mem_pkg::mem_op_type accessOp;
    logic [2:0] rowIndex, answerTarget_reg, periphTarget_reg;
    logic [3:0] columnIndex, operandValue, readValue_reg, periphData_reg;
    logic [3:0] bufferReadData, portReadData, directionReadData, memoryPageSelect_reg;
    logic [3:0] transferWindow_reg, programStatusWord_reg;
    logic       answerValid_reg, skipNext_reg, carryFlag_reg, periphWrite_reg;
    logic [5:0] periphIndex_reg;
    logic [15:0] programAddress_reg;
    logic [11:0] indexModifier_reg;
    logic [7:0] generalRegisterPointer_reg;
    logic [2:0] smallTarget;
    logic [3:0] smallRead;
    int         fail_count = 0, n_checks = 0;
    always #20 clock = ~clock;
    banked_data_memory_map #(.LARGE_VARIANT(1'b1)) uut (.clock, .sys_rst, .accessValid,
        .accessOp, .rowIndex, .columnIndex, .operandValue, .answerValid_reg, .readValue_reg,
        .skipNext_reg, .carryFlag_reg, .answerTarget_reg, .periphWrite_reg, .periphTarget_reg,
        .periphIndex_reg, .periphData_reg, .bufferReadData, .portReadData, .directionReadData,
        .memoryPageSelect_reg, .programAddress_reg, .transferWindow_reg, .indexModifier_reg,
        .generalRegisterPointer_reg, .programStatusWord_reg);
    // small variant sees the same request stream, only its decode and read value are judged
    banked_data_memory_map #(.LARGE_VARIANT(1'b0)) uutSmall (.clock, .sys_rst, .accessValid,
        .accessOp, .rowIndex, .columnIndex, .operandValue, .answerValid_reg(),
        .readValue_reg(smallRead), .skipNext_reg(), .carryFlag_reg(),
        .answerTarget_reg(smallTarget), .periphWrite_reg(), .periphTarget_reg(),
        .periphIndex_reg(), .periphData_reg(), .bufferReadData, .portReadData,
        .directionReadData, .memoryPageSelect_reg(), .programAddress_reg(),
        .transferWindow_reg(), .indexModifier_reg(), .generalRegisterPointer_reg(),
        .programStatusWord_reg());
    core_model core (.clock, .accessValid, .accessOp, .rowIndex, .columnIndex,
        .operandValue, .answerValid_reg);
    // ****************************************
    // helpers
    // ****************************************
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        n_checks++;
        if (got !== exp) begin
            fail_count++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic go(input banked_mem_pkg::mem_op_type op, input logic [6:0] loc,
                      input logic [3:0] val);
        bit ok;
        core.access(op, loc, val, ok);
        chk({15'h0000, ok}, 16'h0001);
    endtask
    task automatic page(input logic [3:0] p);
        go(banked_mem_pkg::OP_WRITE_TO_MEMORY, 7'h79, p);
        chk(memoryPageSelect_reg, p);
    endtask
    task automatic finish_test;
        $display("checks=%0d mismatches=%0d", n_checks, fail_count);
        if (fail_count == 0 && n_checks > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    // ****************************************
    // scenarios
    // ****************************************
    task automatic t_banks;
        chk(memoryPageSelect_reg, 4'h0);
        page(4'h2);
        go(banked_mem_pkg::OP_WRITE_TO_MEMORY, 7'h00, 4'h5);
        page(4'h5);
        go(banked_mem_pkg::OP_WRITE_TO_MEMORY, 7'h00, 4'ha);
        page(4'h2);
        go(banked_mem_pkg::OP_LOAD_FROM_MEMORY, 7'h00, 4'h0);
        chk(readValue_reg, 4'h5);
        chk(answerTarget_reg, 3'd0);
        page(4'hf);
        go(banked_mem_pkg::OP_WRITE_TO_MEMORY, 7'h70, 4'h7);
        go(banked_mem_pkg::OP_LOAD_FROM_MEMORY, 7'h70, 4'h0);
        chk(readValue_reg, 4'h7);
    endtask
    task automatic t_mirror;
        page(4'h5);
        go(banked_mem_pkg::OP_WRITE_TO_MEMORY, 7'h78, 4'h9);
        chk(answerTarget_reg, 3'd1);
        go(banked_mem_pkg::OP_WRITE_TO_MEMORY, 7'h7f, 4'h3);
        go(banked_mem_pkg::OP_WRITE_TO_MEMORY, 7'h74, 4'hd);
        go(banked_mem_pkg::OP_WRITE_TO_MEMORY, 7'h7a, 4'h4);
        go(banked_mem_pkg::OP_WRITE_TO_MEMORY, 7'h7e, 4'h8);
        page(4'h0);
        go(banked_mem_pkg::OP_LOAD_FROM_MEMORY, 7'h78, 4'h0);
        chk(readValue_reg, 4'h9);
        chk(transferWindow_reg, 4'h9);
        chk(programAddress_reg[15:12], 4'hd);
        chk(programStatusWord_reg, 4'h3);
        chk(indexModifier_reg[11:8], 4'h4);
        chk(generalRegisterPointer_reg[3:0], 4'h8);
    endtask
    task automatic t_decode;
        logic [17:0] tbl[10] = '{{4'h0, 7'h0c, 3'd2, 4'ha}, {4'h0, 7'h0f, 3'd2, 4'ha},
            {4'h0, 7'h10, 3'd0, 4'h0}, {4'h3, 7'h73, 3'd3, 4'hb}, {4'h4, 7'h70, 3'd0, 4'h0},
            {4'hf, 7'h60, 3'd4, 4'hc}, {4'hf, 7'h6f, 3'd4, 4'hc}, {4'hf, 7'h5f, 3'd5, 4'h0},
            {4'hf, 7'h00, 3'd5, 4'h0}, {4'h7, 7'h7f, 3'd1, 4'h3}};
        foreach (tbl[i]) begin
            page(tbl[i][17:14]);
            go(banked_mem_pkg::OP_LOAD_FROM_MEMORY, tbl[i][13:7], 4'h0);
            chk(answerTarget_reg, tbl[i][6:4]);
            if (tbl[i][6:4] != 3'd0) chk(readValue_reg, tbl[i][3:0]);
        end
        page(4'hf);
        go(banked_mem_pkg::OP_WRITE_TO_MEMORY, 7'h00, 4'h6);
        chk(periphWrite_reg, 1'b0);
        go(banked_mem_pkg::OP_LOAD_FROM_MEMORY, 7'h00, 4'h0);
        chk(readValue_reg, 4'h0);
        page(4'h1);
        go(banked_mem_pkg::OP_WRITE_TO_MEMORY, 7'h71, 4'he);
        chk({periphWrite_reg, periphTarget_reg, periphIndex_reg, periphData_reg},
            {1'b1, 3'd3, 6'h05, 4'he});
        page(4'ha);
        go(banked_mem_pkg::OP_LOAD_FROM_MEMORY, 7'h10, 4'h0);
        chk({smallTarget, smallRead}, {3'd5, 4'h0});
        go(banked_mem_pkg::OP_LOAD_FROM_MEMORY, 7'h70, 4'h0);
        chk(smallTarget, 3'd5);
        chk(answerTarget_reg, 3'd0);
    endtask
    task automatic t_alu;
        // memory cell 6 against operand 3: value after the op, skip flag
        logic [63:0] res = 64'h9933_2756_6663_6366;
        logic [15:0] sk = 16'h0500;
        page(4'h2);
        for (int i = 0; i < 16; i++) begin
            go(banked_mem_pkg::OP_WRITE_TO_MEMORY, 7'h13, 4'h6);
            go(banked_mem_pkg::mem_op_type'(i[3:0]), 7'h13, 4'h3);
            chk(readValue_reg, 4'h6);
            chk(skipNext_reg, sk[i]);
            go(banked_mem_pkg::OP_LOAD_FROM_MEMORY, 7'h13, 4'h0);
            chk(readValue_reg, res[63-4*i -: 4]);
        end
        go(banked_mem_pkg::OP_WRITE_TO_MEMORY, 7'h13, 4'hf);
        go(banked_mem_pkg::OP_ADD, 7'h13, 4'h3);
        chk(carryFlag_reg, 1'b1);
        go(banked_mem_pkg::OP_ADD_WITH_CARRY, 7'h13, 4'h0);
        go(banked_mem_pkg::OP_LOAD_FROM_MEMORY, 7'h13, 4'h0);
        chk({carryFlag_reg, readValue_reg}, {1'b0, 4'h3});
    endtask
    // ****************************************
    // main sequence and watchdog
    // ****************************************
    initial begin
        bufferReadData = 4'ha;
        portReadData = 4'hb;
        directionReadData = 4'hc;
        repeat (8) @(posedge clock);
        sys_rst <= 1'b0;
        t_banks();
        t_mirror();
        t_decode();
        t_alu();
        finish_test();
    end
    initial begin
        #200us;
        fail_count++;
        finish_test();
    end
endmodule
`default_nettype wire
